// ### verilog/tlbm_top.sv
// translation buffer maintenance registers: entry window, replacement,
// micro-buffer flush, address space and fault cause
// assumes one core clock and a load/store control port from the pipeline
//
// Summary of operation
// - entry word two holds virtual page bits
// - large pages compare only top 10/4 bits
// - entry word three holds physical page bits
// - window words map entry bits 64..159, last zero
// - replacement resets random ffff, count 40
// - random from 16-bit LFSR, taps 3,12,14,15
// - replacement read returns value then advances
// - replacement write loads random and count
// - entry count is plain storage only
// - flush bits invalidate micro-buffers, read zero
// - flush waits for pending entry writes
// - address-space write flushes both micro-buffers
// - entry write effective six cycles later
// - return from interrupt clears instruction buffer
// - fault cause code recorded in bits 17:16
// - fault index and presence flag recorded
// - bit 18 marks speculative or purge origin
// - bit 19 marks store origin
// - data faults raised even if only micro-buffered
// - window accesses target selected entry
// - unified buffer holds 64 software-managed entries
`timescale 1ns/1ps
`default_nettype none
`include "tlbm_params.svh"
module tlbm_top
    import tlbm_pkg::*;
#(
    parameter int ENTRIES = 64,
    parameter int AW      = 6
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        reg_req_i,
    input  wire logic        reg_we_i,
    input  wire logic [3:0]  reg_sel_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic [7:0]  entry_select_i,
    input  wire logic        lookup_valid_i,
    input  wire logic [18:0] lookup_va_i,
    input  wire tlbm_size_t  lookup_size_i,
    input  wire logic        fault_valid_i,
    input  wire tlbm_cause_t fault_cause_i,
    input  wire logic [7:0]  fault_index_i,
    input  wire logic        fault_present_i,
    input  wire logic        fault_speculative_origin_flag_i,
    input  wire logic        fault_store_i,
    input  wire logic        rfi_i,
    output var  logic        reg_ack_o,
    output var  logic [31:0] reg_rdata_o,
    output var  logic        lookup_hit_o,
    output var  logic        fault_raise_o,
    output var  logic        ibuf_clear_o,
    output var  logic        instr_micro_flush_o,
    output var  logic        data_micro_flush_o,
    output var  logic        entry_write_busy_o,
    output var  logic [7:0]  asid_o
);
    logic        rst_q1;
    logic        rst_n;
    logic        rd_req;
    logic        wr_req;
    logic        entry_ok;
    logic        wr_busy;
    logic        fire;
    logic        pend_i;
    logic        pend_d;
    logic        new_i;
    logic        new_d;
    logic [15:0] rand_q;
    logic [7:0]  count_q;
    logic [7:0]  cause_index;
    tlbm_cause_t cause_code;
    logic        cause_speculative_origin_flag;
    logic        cause_store;
    logic        cause_present;
    logic [31:0] next_rdata;
    tlbm_wr_t    wr_pipe [`TLBM_WR_DELAY];
    logic [`TLBM_WR_DELAY-1:0] pipe_vld;

    tlbm_mem_if #(.AW(AW)) mif ();

    // reset released through two flops
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    assign rd_req   = reg_req_i && !reg_we_i;
    assign wr_req   = reg_req_i && reg_we_i;
    // selects beyond the populated entries are ignored
    assign entry_ok = entry_select_i < 8'(ENTRIES);

    function automatic logic page_match(input logic [18:0] a,
                                        input logic [18:0] b,
                                        input tlbm_size_t sz);
        logic [18:0] msk;
        unique case (sz)
            TLBM_SZ_8K:   msk = `TLBM_MASK_8K;
            TLBM_SZ_4M:   msk = `TLBM_MASK_4M;
            TLBM_SZ_256M: msk = `TLBM_MASK_256M;
            TLBM_SZ_OFF:  msk = 19'h00000;
        endcase
        return (sz != TLBM_SZ_OFF) && ((a & msk) == (b & msk));
    endfunction : page_match

    // entry store, read continuously at the selected entry
    assign mif.rd_idx = entry_select_i[AW-1:0];

    tlbm_entry_mem #(.DEPTH(ENTRIES), .AW(AW)) i_tlbm_entry_mem (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .m       (mif.mem)
    );

    // write delay line gives the six-cycle settle time of an entry write
    generate
        for (genvar s = 0; s < `TLBM_WR_DELAY; s++) begin : g_wr
            assign pipe_vld[s] = wr_pipe[s].vld;
            if (s == 0) begin : g_head
                always_ff @(posedge clk_i or negedge rst_n) begin
                    if (!rst_n) begin
                        wr_pipe[s] <= '0;
                    end else begin
                        wr_pipe[s].vld  <= wr_req && entry_ok &&
                            (reg_sel_i == `TLBM_SEL_VPAGE ||
                             reg_sel_i == `TLBM_SEL_PPAGE);
                        wr_pipe[s].phys <= reg_sel_i == `TLBM_SEL_PPAGE;
                        wr_pipe[s].idx  <= entry_select_i[AW-1:0];
                        // upper bits dropped: reserved in both words
                        wr_pipe[s].data <= reg_wdata_i[`TLBM_PAGE_MSB:0];
                    end
                end
            end else begin : g_tail
                always_ff @(posedge clk_i or negedge rst_n) begin
                    if (!rst_n) begin
                        wr_pipe[s] <= '0;
                    end else begin
                        wr_pipe[s] <= wr_pipe[s-1];
                    end
                end
            end
        end
    endgenerate

    assign mif.wr_en   = wr_pipe[`TLBM_WR_DELAY-1].vld;
    assign mif.wr_phys = wr_pipe[`TLBM_WR_DELAY-1].phys;
    assign mif.wr_idx  = wr_pipe[`TLBM_WR_DELAY-1].idx;
    assign mif.wr_data = wr_pipe[`TLBM_WR_DELAY-1].data;
    assign wr_busy     = |pipe_vld;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            entry_write_busy_o <= 1'b0;
        end else begin
            entry_write_busy_o <= wr_busy || (wr_req && entry_ok);
        end
    end

    // replacement register; the count never feeds any lookup path
    tlbm_lfsr i_tlbm_lfsr (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n),
        .load_i     (wr_req && reg_sel_i == `TLBM_SEL_REPLACE),
        .load_val_i (reg_wdata_i[`TLBM_RAND_MSB:0]),
        .step_i     (rd_req && reg_sel_i == `TLBM_SEL_REPLACE),
        .value_o    (rand_q)
    );

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= `TLBM_COUNT_RST;
        end else if (wr_req && reg_sel_i == `TLBM_SEL_REPLACE) begin
            count_q <= reg_wdata_i[`TLBM_COUNT_MSB:`TLBM_COUNT_LSB];
        end
    end

    // address space identifier
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            asid_o <= `TLBM_ASID_RST;
        end else if (wr_req && reg_sel_i == `TLBM_SEL_ASID) begin
            asid_o <= reg_wdata_i[7:0];
        end
    end

    // flush requests gather here and fire once entry writes drain
    assign new_i = wr_req && ((reg_sel_i == `TLBM_SEL_FLUSH &&
                   reg_wdata_i[`TLBM_FLUSH_I_BIT]) ||
                   reg_sel_i == `TLBM_SEL_ASID);
    assign new_d = wr_req && ((reg_sel_i == `TLBM_SEL_FLUSH &&
                   reg_wdata_i[`TLBM_FLUSH_D_BIT]) ||
                   reg_sel_i == `TLBM_SEL_ASID);
    assign fire  = (pend_i || pend_d) && !wr_busy;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pend_i <= 1'b0;
            pend_d <= 1'b0;
        end else begin
            // a new request in the firing cycle survives the clear
            pend_i <= (pend_i && !fire) || new_i;
            pend_d <= (pend_d && !fire) || new_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            instr_micro_flush_o <= 1'b0;
            data_micro_flush_o  <= 1'b0;
        end else begin
            instr_micro_flush_o <= fire && pend_i;
            data_micro_flush_o  <= fire && pend_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ibuf_clear_o <= 1'b0;
        end else begin
            ibuf_clear_o <= rfi_i;
        end
    end

    // fault cause; a hardware capture beats a same-cycle software write
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cause_index   <= 8'h00;
            cause_code    <= TLBM_NO_MAPPING;
            cause_speculative_origin_flag    <= 1'b0;
            cause_store   <= 1'b0;
            cause_present <= 1'b0;
        end else if (fault_valid_i) begin
            cause_code    <= fault_cause_i;
            cause_index   <= fault_index_i;
            cause_present <= fault_present_i;
            cause_speculative_origin_flag    <= fault_speculative_origin_flag_i;
            cause_store   <= fault_store_i;
        end else if (wr_req && reg_sel_i == `TLBM_SEL_CAUSE) begin
            cause_index   <= reg_wdata_i[7:0];
            cause_code    <= tlbm_cause_t'(
                reg_wdata_i[`TLBM_CAUSE_MSB:`TLBM_CAUSE_LSB]);
            cause_speculative_origin_flag    <= reg_wdata_i[`TLBM_SPECULATIVE_ORIGIN_FLAG_BIT];
            cause_store   <= reg_wdata_i[`TLBM_STORE_BIT];
            cause_present <= reg_wdata_i[`TLBM_PRESENT_BIT];
        end
    end

    // raised whatever buffer holds the page
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fault_raise_o <= 1'b0;
        end else begin
            fault_raise_o <= fault_valid_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lookup_hit_o <= 1'b0;
        end else begin
            lookup_hit_o <= lookup_valid_i && entry_ok &&
                page_match(lookup_va_i, mif.rd_vpage, lookup_size_i);
        end
    end

    // read mux; every reserved position is forced to zero
    always_comb begin
        next_rdata = 32'h00000000;
        unique case (reg_sel_i)
            `TLBM_SEL_VPAGE: begin
                if (entry_ok) next_rdata[18:0] = mif.rd_vpage;
            end
            `TLBM_SEL_PPAGE: begin
                if (entry_ok) next_rdata[18:0] = mif.rd_ppage;
            end
            `TLBM_SEL_REPLACE: begin
                next_rdata[23:0] = {count_q, rand_q};
            end
            `TLBM_SEL_ASID: begin
                next_rdata[7:0] = asid_o;
            end
            `TLBM_SEL_CAUSE: begin
                next_rdata[20:0] = {cause_present, cause_store, cause_speculative_origin_flag,
                                    cause_code, 8'h00, cause_index};
            end
            default: begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_ack_o   <= 1'b0;
            reg_rdata_o <= 32'h00000000;
        end else begin
            reg_ack_o   <= reg_req_i;
            reg_rdata_o <= rd_req ? next_rdata : 32'h00000000;
        end
    end

    property p_rsvd_zero;
        @(posedge clk_i) disable iff (!rst_n)
        rd_req && reg_sel_i inside {`TLBM_SEL_VPAGE, `TLBM_SEL_PPAGE}
        |=> reg_rdata_o[31:19] == 13'h0000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("page word reserved bits not zero");

    property p_word3_zero;
        @(posedge clk_i) disable iff (!rst_n)
        rd_req && reg_sel_i == `TLBM_SEL_RSVD |=> reg_rdata_o == 32'h0;
    endproperty
    a_word3_zero: assert property (p_word3_zero)
        else $error("reserved entry word read non-zero");

    property p_rep_read;
        @(posedge clk_i) disable iff (!rst_n)
        rd_req && reg_sel_i == `TLBM_SEL_REPLACE |=>
        reg_rdata_o[15:0] == $past(rand_q) && rand_q != $past(rand_q);
    endproperty
    a_rep_read: assert property (p_rep_read)
        else $error("replacement read value or advance wrong");

    property p_rep_write;
        @(posedge clk_i) disable iff (!rst_n)
        wr_req && reg_sel_i == `TLBM_SEL_REPLACE |=>
        {count_q, rand_q} == $past(reg_wdata_i[23:0]);
    endproperty
    a_rep_write: assert property (p_rep_write)
        else $error("replacement write not loaded");

    property p_flush_read_zero;
        @(posedge clk_i) disable iff (!rst_n)
        rd_req && reg_sel_i == `TLBM_SEL_FLUSH |=> reg_rdata_o == 32'h0;
    endproperty
    a_flush_read_zero: assert property (p_flush_read_zero)
        else $error("flush register read non-zero");

    property p_asid_flush;
        @(posedge clk_i) disable iff (!rst_n)
        wr_req && reg_sel_i == `TLBM_SEL_ASID && !wr_busy
        |=> ##1 instr_micro_flush_o && data_micro_flush_o;
    endproperty
    a_asid_flush: assert property (p_asid_flush)
        else $error("address space write did not flush both");

    property p_flush_after_writes;
        @(posedge clk_i) disable iff (!rst_n)
        wr_req && entry_ok && reg_sel_i inside {`TLBM_SEL_VPAGE,
            `TLBM_SEL_PPAGE}
        |=> ##1 !(instr_micro_flush_o || data_micro_flush_o) [*6];
    endproperty
    a_flush_after_writes: assert property (p_flush_after_writes)
        else $error("flush fired with entry write pending");

    property p_wr_delay;
        @(posedge clk_i) disable iff (!rst_n)
        wr_req && entry_ok && reg_sel_i == `TLBM_SEL_PPAGE
        |-> ##6 (mif.wr_en && mif.wr_phys &&
                 mif.wr_idx == $past(entry_select_i[AW-1:0], 6));
    endproperty
    a_wr_delay: assert property (p_wr_delay)
        else $error("entry write did not land six cycles later");

    property p_fault_capture;
        @(posedge clk_i) disable iff (!rst_n)
        fault_valid_i |=> cause_code == $past(fault_cause_i) &&
        cause_present == $past(fault_present_i) &&
        cause_store == $past(fault_store_i) &&
        cause_index == $past(fault_index_i) &&
        cause_speculative_origin_flag == $past(fault_speculative_origin_flag_i) && fault_raise_o;
    endproperty
    a_fault_capture: assert property (p_fault_capture)
        else $error("fault cause not captured");

    property p_rfi;
        @(posedge clk_i) disable iff (!rst_n)
        rfi_i |=> ibuf_clear_o;
    endproperty
    a_rfi: assert property (p_rfi)
        else $error("return did not clear instruction buffer");

    c_merge: cover property (@(posedge clk_i) disable iff (!rst_n)
        instr_micro_flush_o && data_micro_flush_o);
    c_wait: cover property (@(posedge clk_i) disable iff (!rst_n)
        (pend_i || pend_d) && wr_busy);
    c_fault: cover property (@(posedge clk_i) disable iff (!rst_n)
        fault_valid_i && fault_speculative_origin_flag_i);
endmodule : tlbm_top
`default_nettype wire

// ### verilog/tlbm_params.svh
// constants for the translation buffer maintenance registers
// assumes inclusion by bare name from the package and design modules
`ifndef TLBM_PARAMS_SVH
`define TLBM_PARAMS_SVH
// register select codes on the load/store control port
`define TLBM_SEL_VPAGE    4'h0
`define TLBM_SEL_PPAGE    4'h1
`define TLBM_SEL_RSVD     4'h2
`define TLBM_SEL_REPLACE  4'h3
`define TLBM_SEL_FLUSH    4'h4
`define TLBM_SEL_ASID     4'h5
`define TLBM_SEL_CAUSE    4'h6
// field layout
`define TLBM_PAGE_MSB     18
`define TLBM_RAND_MSB     15
`define TLBM_COUNT_LSB    16
`define TLBM_COUNT_MSB    23
`define TLBM_FLUSH_I_BIT  0
`define TLBM_FLUSH_D_BIT  1
`define TLBM_CAUSE_LSB    16
`define TLBM_CAUSE_MSB    17
`define TLBM_SPECULATIVE_ORIGIN_FLAG_BIT     18
`define TLBM_STORE_BIT    19
`define TLBM_PRESENT_BIT  20
// reset values
`define TLBM_RAND_RST     16'hffff
`define TLBM_COUNT_RST    8'h40
`define TLBM_ASID_RST     8'h00
// significant page bits per page size
`define TLBM_MASK_8K      19'h7ffff
`define TLBM_MASK_4M      19'h7fe00
`define TLBM_MASK_256M    19'h78000
// cycles from an entry write to its effect
`define TLBM_WR_DELAY     6
`endif

// ### verilog/tlbm_pkg.sv
// types shared by the maintenance register modules
// assumes tlbm_params.svh on the include path
`default_nettype none
`include "tlbm_params.svh"
package tlbm_pkg;
    typedef enum logic [1:0] {
        TLBM_NO_MAPPING,
        TLBM_FAULT_PERMISSION,
        TLBM_FAULT_CLEAN_PAGE_STORE,
        TLBM_MULTI_HIT
    } tlbm_cause_t;
    typedef enum logic [1:0] {
        TLBM_SZ_OFF,
        TLBM_SZ_8K,
        TLBM_SZ_4M,
        TLBM_SZ_256M
    } tlbm_size_t;
    typedef struct packed {
        logic        vld;
        logic        phys;
        logic [5:0]  idx;
        logic [18:0] data;
    } tlbm_wr_t;
endpackage : tlbm_pkg
`default_nettype wire

// ### verilog/tlbm_mem_if.sv
// link between the register logic and the entry store
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface tlbm_mem_if #(parameter int AW = 6);
    logic [AW-1:0] rd_idx;
    logic [18:0]   rd_vpage;
    logic [18:0]   rd_ppage;
    logic          wr_en;
    logic          wr_phys;
    logic [AW-1:0] wr_idx;
    logic [18:0]   wr_data;
    modport ctl (output rd_idx, wr_en, wr_phys, wr_idx, wr_data,
                 input rd_vpage, rd_ppage);
    modport mem (input rd_idx, wr_en, wr_phys, wr_idx, wr_data,
                 output rd_vpage, rd_ppage);
endinterface : tlbm_mem_if
`default_nettype wire

// ### verilog/tlbm_lfsr.sv
// 16-bit maximal-length replacement shift register
// assumes synchronous reset copy from the top module
`timescale 1ns/1ps
`default_nettype none
`include "tlbm_params.svh"
module tlbm_lfsr
    import tlbm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        load_i,
    input  wire logic [15:0] load_val_i,
    input  wire logic        step_i,
    output var  logic [15:0] value_o
);
    logic fb;

    assign fb = value_o[15] ^ value_o[14] ^ value_o[12] ^ value_o[3];

    // load wins over step when both arrive together
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            value_o <= `TLBM_RAND_RST;
        end else if (load_i) begin
            value_o <= load_val_i;
        end else if (step_i) begin
            value_o <= {value_o[14:0], fb};
        end
    end

    property p_lfsr_step;
        @(posedge clk_i) disable iff (!rst_n_i)
        step_i && !load_i |=> value_o == {$past(value_o[14:0]), $past(fb)};
    endproperty
    a_lfsr_step: assert property (p_lfsr_step)
        else $error("shift register did not advance on step");
endmodule : tlbm_lfsr
`default_nettype wire

// ### verilog/tlbm_entry_mem.sv
// upper words of the unified translation entries
// assumes contents are programmed by software before use
`timescale 1ns/1ps
`default_nettype none
module tlbm_entry_mem #(
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    tlbm_mem_if.mem   m
);
    logic [18:0] vpage_mem [DEPTH];
    logic [18:0] ppage_mem [DEPTH];

    // no reset on the arrays: contents undefined until programmed
    always_ff @(posedge clk_i) begin
        if (m.wr_en && !m.wr_phys) begin
            vpage_mem[m.wr_idx] <= m.wr_data;
        end
        if (m.wr_en && m.wr_phys) begin
            ppage_mem[m.wr_idx] <= m.wr_data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            m.rd_vpage <= 19'h00000;
            m.rd_ppage <= 19'h00000;
        end else begin
            m.rd_vpage <= vpage_mem[m.rd_idx];
            m.rd_ppage <= ppage_mem[m.rd_idx];
        end
    end
endmodule : tlbm_entry_mem
`default_nettype wire

// ### sim/tb_tlbm_top.sv
// self-checking bench for the translation buffer maintenance registers
// assumes tlbm_pkg compiled first; bench drives every port of tlbm_top
`timescale 1ns/1ps
`default_nettype none
module tb_tlbm_top;
    import tlbm_pkg::*;
    logic              clk_i = 1'b0;
    logic              rstn_i = 1'b0;
    logic              reg_req_i = 1'b0;
    logic              reg_we_i = 1'b0;
    logic [3:0]        reg_sel_i = 4'h0;
    logic [31:0]       reg_wdata_i = 32'h0;
    logic [7:0]        entry_select_i = 8'h05;
    logic              lookup_valid_i = 1'b0;
    logic [18:0]       lookup_va_i = 19'h0;
    tlbm_size_t        lookup_size_i = TLBM_SZ_OFF;
    logic              fault_valid_i = 1'b0;
    tlbm_cause_t       fault_cause_i = TLBM_NO_MAPPING;
    logic [7:0]        fault_index_i = 8'h0;
    logic              fault_present_i = 1'b0;
    logic              fault_speculative_origin_flag_i = 1'b0;
    logic              fault_store_i = 1'b0;
    logic              rfi_i = 1'b0;
    logic              reg_ack_o;
    logic [31:0]       reg_rdata_o;
    logic              lookup_hit_o;
    logic              fault_raise_o;
    logic              ibuf_clear_o;
    logic              instr_micro_flush_o;
    logic              data_micro_flush_o;
    logic              entry_write_busy_o;
    logic [7:0]        asid_o;
    int                fails = 0;
    int                n_checks = 0;
    int                n_i = 0;
    int                n_d = 0;
    int                n_bad = 0;
    int                cyc = 0;
    logic [31:0]       rd;
    logic [31:0]       r1;

    tlbm_top i_tlbm_top (.clk_i(clk_i), .rstn_i(rstn_i),
        .reg_req_i(reg_req_i), .reg_we_i(reg_we_i), .reg_sel_i(reg_sel_i),
        .reg_wdata_i(reg_wdata_i), .entry_select_i(entry_select_i),
        .lookup_valid_i(lookup_valid_i), .lookup_va_i(lookup_va_i),
        .lookup_size_i(lookup_size_i), .fault_valid_i(fault_valid_i),
        .fault_cause_i(fault_cause_i), .fault_index_i(fault_index_i),
        .fault_present_i(fault_present_i), .fault_speculative_origin_flag_i(fault_speculative_origin_flag_i),
        .fault_store_i(fault_store_i), .rfi_i(rfi_i),
        .reg_ack_o(reg_ack_o), .reg_rdata_o(reg_rdata_o),
        .lookup_hit_o(lookup_hit_o), .fault_raise_o(fault_raise_o),
        .ibuf_clear_o(ibuf_clear_o),
        .instr_micro_flush_o(instr_micro_flush_o),
        .data_micro_flush_o(data_micro_flush_o),
        .entry_write_busy_o(entry_write_busy_o), .asid_o(asid_o));

    always #10 clk_i = ~clk_i;

    // sampled on the falling edge so registered pulses have settled
    always @(negedge clk_i) begin
        if (instr_micro_flush_o === 1'b1) n_i++;
        if (data_micro_flush_o === 1'b1) n_d++;
        if ((instr_micro_flush_o | data_micro_flush_o) && entry_write_busy_o)
            n_bad++;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask : chk

    // one request, answer one cycle later with the acknowledge
    task automatic acc(input logic we, input logic [3:0] sel,
                       input logic [31:0] wd, output logic [31:0] r);
        @(posedge clk_i);
        reg_req_i   <= 1'b1;
        reg_we_i    <= we;
        reg_sel_i   <= sel;
        reg_wdata_i <= wd;
        @(posedge clk_i);
        reg_req_i <= 1'b0;
        #1;
        chk("ack", {31'h0, reg_ack_o}, 32'h1);
        r = reg_rdata_o;
    endtask : acc

    task automatic t_reset_vals;
        acc(1'b0, 4'h3, 32'h0, rd);
        chk("replace rst", rd, 32'h0040ffff);
        chk("pick", ({16'h0, rd[15:0]} * {24'h0, rd[23:16]}) >> 16,
            32'h3f);
        acc(1'b0, 4'h3, 32'h0, r1);
        chk("lfsr moved", {16'h0, r1[15:0]}, 32'hfffe);
        chk("count kept", {8'h0, r1[23:16]}, 32'h40);
        acc(1'b1, 4'h3, 32'hffff_1234, rd);
        acc(1'b0, 4'h3, 32'h0, rd);
        chk("replace wr", rd, 32'h00ff1234);
        acc(1'b0, 4'h3, 32'h0, rd);
        chk("lfsr step", rd, 32'h00ff2469);
        acc(1'b0, 4'h4, 32'h0, rd);
        chk("flush rd", rd, 32'h0);
        acc(1'b0, 4'h6, 32'h0, rd);
        chk("cause rst", rd, 32'h0);
        acc(1'b0, 4'h9, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        $display("test reset values done");
    endtask : t_reset_vals

    task automatic t_entries;
        acc(1'b1, 4'h0, 32'hffff_ffff, rd);
        chk("busy", {31'h0, entry_write_busy_o}, 32'h1);
        acc(1'b1, 4'h1, 32'hfff5_4321, rd);
        acc(1'b1, 4'h2, 32'hffff_ffff, rd);
        @(posedge clk_i);
        entry_select_i <= 8'h06;
        acc(1'b1, 4'h0, 32'h0001_2345, rd);
        repeat (8) @(posedge clk_i);
        entry_select_i <= 8'h05;
        repeat (2) @(posedge clk_i);
        acc(1'b0, 4'h0, 32'h0, rd);
        chk("vpage", rd, 32'h0007ffff);
        acc(1'b0, 4'h1, 32'h0, rd);
        chk("ppage", rd, 32'h00054321);
        acc(1'b0, 4'h2, 32'h0, rd);
        chk("rsvd word", rd, 32'h0);
        // no entry behind selects past the populated range
        @(posedge clk_i);
        entry_select_i <= 8'h40;
        acc(1'b1, 4'h0, 32'h0000_0001, rd);
        chk("no entry", {31'h0, entry_write_busy_o}, 32'h0);
        acc(1'b0, 4'h0, 32'h0, rd);
        chk("no entry rd", rd, 32'h0);
        @(posedge clk_i);
        entry_select_i <= 8'h05;
        $display("test entry window done");
    endtask : t_entries

    task automatic look(input logic [18:0] va, input tlbm_size_t sz,
                        input logic exp);
        @(posedge clk_i);
        lookup_valid_i <= 1'b1;
        lookup_va_i    <= va;
        lookup_size_i  <= sz;
        @(posedge clk_i);
        lookup_valid_i <= 1'b0;
        #1;
        chk("hit", {31'h0, lookup_hit_o}, {31'h0, exp});
    endtask : look

    task automatic flush(input logic [3:0] sel, input logic [31:0] wd,
                         input int ei, input int ed, input logic pre);
        n_i = 0;
        n_d = 0;
        if (pre) acc(1'b1, 4'h1, 32'h0000_0abc, rd);
        acc(1'b1, sel, wd, rd);
        repeat (12) @(posedge clk_i);
        chk("i pulses", n_i, ei);
        chk("d pulses", n_d, ed);
        chk("busy flush", n_bad, 32'h0);
    endtask : flush

    task automatic fault(input tlbm_cause_t c, input logic [7:0] ix,
                         input logic p, sp, st);
        @(posedge clk_i);
        fault_valid_i   <= 1'b1;
        fault_cause_i   <= c;
        fault_index_i   <= ix;
        fault_present_i <= p;
        fault_speculative_origin_flag_i    <= sp;
        fault_store_i   <= st;
        @(posedge clk_i);
        fault_valid_i <= 1'b0;
        #1;
        chk("raise", {31'h0, fault_raise_o}, 32'h1);
        acc(1'b0, 4'h6, 32'h0, rd);
        chk("cause", rd, {11'h0, p, st, sp, c, 8'h0, ix});
    endtask : fault

    initial begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_reset_vals();
        t_entries();
        look(19'h7ffff, TLBM_SZ_8K, 1'b1);
        look(19'h7fe01, TLBM_SZ_8K, 1'b0);
        look(19'h7fe00, TLBM_SZ_4M, 1'b1);
        look(19'h3fe00, TLBM_SZ_4M, 1'b0);
        look(19'h78000, TLBM_SZ_256M, 1'b1);
        look(19'h7ffff, TLBM_SZ_OFF, 1'b0);
        $display("test lookup done");
        flush(4'h4, 32'hffff_fffc, 0, 0, 1'b0);
        flush(4'h4, 32'h0000_0001, 1, 0, 1'b0);
        flush(4'h4, 32'h0000_0002, 0, 1, 1'b1);
        flush(4'h4, 32'h0000_0003, 1, 1, 1'b1);
        // twelve quiet cycles follow, longer than the eight-bundle margin
        flush(4'h5, 32'hffff_ffab, 1, 1, 1'b0);
        chk("asid out", {24'h0, asid_o}, 32'hab);
        acc(1'b0, 4'h5, 32'h0, rd);
        chk("asid rd", rd, 32'hab);
        $display("test flush done");
        fault(TLBM_NO_MAPPING, 8'h3f, 1'b0, 1'b1, 1'b0);
        fault(TLBM_FAULT_PERMISSION, 8'h05, 1'b1, 1'b0, 1'b1);
        fault(TLBM_FAULT_CLEAN_PAGE_STORE, 8'h00, 1'b0, 1'b0, 1'b1);
        fault(TLBM_MULTI_HIT, 8'hc2, 1'b1, 1'b1, 1'b0);
        $display("test fault done");
        @(posedge clk_i);
        rfi_i <= 1'b1;
        @(posedge clk_i);
        rfi_i <= 1'b0;
        #1;
        chk("ibuf clear", {31'h0, ibuf_clear_o}, 32'h1);
        $display("test return done");
        print_verdict();
    end
endmodule : tb_tlbm_top
`default_nettype wire
